/* dv/rpn_proc_model.sv */
// Behavioural arithmetic processor on the far side of the function port.
// Assumes fn_req is a one-cycle pulse on the same clock as the stack.
`timescale 1ns/1ps

module rpn_proc_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic fn_req,
  input wire logic [4:0] fn_code,
  input wire rpn_pkg::rpn_item_t op_a,
  input wire rpn_pkg::rpn_item_t op_b,
  output logic res_valid,
  output rpn_pkg::rpn_item_t res_item
);
  // ----------------------------------------------------------------
  // Result: first operand (op_a) with its sign inverted
  // ----------------------------------------------------------------
  logic busy_r;
  logic [3:0] cnt_r;
  rpn_pkg::rpn_item_t hold_r;
  rpn_pkg::rpn_item_t res_nxt;

  always_comb begin
    res_nxt = op_a;
    res_nxt.neg = ~op_a.neg;
  end

  // Odd function codes answer slowly to exercise the wait state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      hold_r <= '0;
    end else if (fn_req) begin
      busy_r <= 1'b1;
      cnt_r <= fn_code[0] ? 4'h6 : 4'h0;
      hold_r <= res_nxt;
    end else if (busy_r) begin
      busy_r <= (cnt_r != 4'h0);
      cnt_r <= cnt_r - ((cnt_r != 4'h0) ? 4'h1 : 4'h0);
    end
  end

  assign res_valid = busy_r && (cnt_r == 4'h0);
  // Stale result is not held: inverse shown outside the strobe
  assign res_item = res_valid ? hold_r : ~hold_r;
endmodule // rpn_proc_model

/* dv/tb.sv */
// Self-checking bench for the operand stack and entry parser.
// Assumes the processor model answers every function request.
`timescale 1ns/1ps

module tb;
  logic clock, rstn, key_valid, key_ready, entry_warn, fn_req, res_valid;
  logic [4:0] fn_code;
  rpn_pkg::rpn_key_t key;
  rpn_pkg::rpn_item_t x_disp, y_disp, op_a, op_b, res_item;
  rpn_pkg::rpn_entry_t entry_disp;
  int errors, n_tests, i;

  rpn_stack_entry i_rpn_stack_entry (.clock(clock), .rstn(rstn), .key_valid(key_valid),
    .key(key), .key_ready(key_ready), .entry_warn(entry_warn), .x_disp(x_disp),
    .y_disp(y_disp), .entry_disp(entry_disp), .fn_req(fn_req), .fn_code(fn_code),
    .op_a(op_a), .op_b(op_b), .res_valid(res_valid), .res_item(res_item));
  rpn_proc_model i_rpn_proc_model (.clock(clock), .rstn(rstn), .fn_req(fn_req),
    .fn_code(fn_code), .op_a(op_a), .op_b(op_b), .res_valid(res_valid),
    .res_item(res_item));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_item(string name, rpn_pkg::rpn_item_t exp, rpn_pkg::rpn_item_t got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic rpn_pkg::rpn_item_t mk(logic n, logic [1:0] ip, logic [15:0] m,
                                            logic [7:0] e);
    mk = '{1'b0, n, ip, m, e};
  endfunction

  // Holds the key until the edge that takes it, then lets results land
  task automatic press(rpn_pkg::rpn_kind_t k, logic [4:0] v);
    int n;
    n = 0;
    @(posedge clock);
    key_valid <= 1'b1;
    key <= '{k, v};
    @(negedge clock);
    while (key_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    if (n >= 50) cmp("key_ready", 32'h1, 32'(key_ready));
    @(posedge clock);
    key_valid <= 1'b0;
    @(negedge clock);
  endtask

  task automatic dig(int d);
    press(rpn_pkg::DIGIT_KEY, 5'(d));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mantissa;
    cmp_item("x_reset", '0, x_disp);
    cmp("ready_reset", 32'h1, 32'(key_ready));
    dig(8);
    dig(5);
    cmp("digs", 32'h58, 32'({entry_disp.digs[1], entry_disp.digs[0]}));
    cmp("sign_init", 32'h0, 32'(entry_disp.neg));
    for (i = 0; i < 3; i++) begin
      press(rpn_pkg::SIGN_TOGGLE_KEY, 5'h00);
      cmp("sign", 32'(i % 2 == 0), 32'(entry_disp.neg));
    end
    press(rpn_pkg::ENTER_KEY, 5'h00);
    cmp_item("x_85", mk(1'b1, 2'h1, 16'h8500, 8'h00), x_disp);
    cmp("active", 32'h0, 32'(entry_disp.active));
  endtask

  task automatic t_point;
    dig(1);
    press(rpn_pkg::POINT_KEY, 5'h00);
    cmp("warn_pt1", 32'h0, 32'(entry_warn));
    press(rpn_pkg::POINT_KEY, 5'h00);
    cmp("warn_pt2", 32'h1, 32'(entry_warn));
    dig(5);
    cmp("warn_pulse", 32'h0, 32'(entry_warn));
    press(rpn_pkg::ENTER_KEY, 5'h00);
    cmp_item("x_1p5", mk(1'b0, 2'h0, 16'h1500, 8'h00), x_disp);
  endtask

  task automatic t_twelve;
    for (i = 0; i < 12; i++) begin
      dig(1);
      cmp("warn_ch", 32'h0, 32'(entry_warn));
    end
    dig(1);
    cmp("warn_13", 32'h1, 32'(entry_warn));
    press(rpn_pkg::ENTER_KEY, 5'h00);
    cmp_item("x_long", mk(1'b0, 2'h2, 16'h1111, 8'h09), x_disp);
  endtask

  task automatic t_expo;
    press(rpn_pkg::EXPONENT_ENTRY_KEY, 5'h00);
    cmp("warn_eex", 32'h0, 32'(entry_warn));
    dig(1);
    dig(2);
    dig(3);
    cmp("edig", 32'h23, 32'({entry_disp.edig[1], entry_disp.edig[0]}));
    press(rpn_pkg::POINT_KEY, 5'h00);
    cmp("warn_ept", 32'h1, 32'(entry_warn));
    press(rpn_pkg::EXPONENT_ENTRY_KEY, 5'h00);
    cmp("warn_eex2", 32'h1, 32'(entry_warn));
    press(rpn_pkg::SIGN_TOGGLE_KEY, 5'h00);
    cmp("eneg", 32'h1, 32'(entry_disp.eneg));
    press(rpn_pkg::ENTER_KEY, 5'h00);
    cmp_item("x_exp", mk(1'b0, 2'h1, 16'h1000, 8'he8), x_disp);
  endtask

  task automatic t_shift;
    dig(4);
    press(rpn_pkg::SHIFT_KEY, 5'h00);
    cmp("blank", 32'h5, 32'(entry_disp.blank));
    cmp("digs_kept", 32'h4, 32'(entry_disp.digs[0]));
    press(rpn_pkg::SHIFT_CLEAR_KEY, 5'h00);
    cmp("unblank", 32'h0, 32'(entry_disp.blank));
    press(rpn_pkg::ENTER_KEY, 5'h00);
    cmp_item("x_4", mk(1'b0, 2'h0, 16'h4000, 8'h00), x_disp);
  endtask

  task automatic t_stack;
    logic [3:0] xs [5] = '{4'h5, 4'h4, 4'h3, 4'h2, 4'h2};
    for (i = 1; i <= 6; i++) begin
      dig(i);
      press(rpn_pkg::ENTER_KEY, 5'h00);
    end
    cmp_item("y_push", mk(1'b0, 2'h0, 16'h5000, 8'h00), y_disp);
    for (i = 0; i < 5; i++) begin
      press(rpn_pkg::CLEAR_ENTRY_POP_KEY, 5'h00);
      cmp_item("x_pop", mk(1'b0, 2'h0, {xs[i], 12'h000}, 8'h00), x_disp);
      cmp_item("y_pop", mk(1'b0, 2'h0, {(i < 3) ? xs[i+1] : 4'h2, 12'h000}, 8'h00),
               y_disp);
    end
  endtask

  task automatic t_func;
    int n;
    n = 0;
    dig(1);
    press(rpn_pkg::ENTER_KEY, 5'h00);
    dig(2);
    press(rpn_pkg::FUNC2_KEY, 5'h01);
    cmp("ready_busy", 32'h0, 32'(key_ready));
    while (fn_req !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    cmp("fn_lat", 32'h1, 32'(n));
    cmp("fn_code", 32'h1, 32'(fn_code));
    cmp_item("op_b", mk(1'b0, 2'h0, 16'h2000, 8'h00), op_b);
    cmp_item("op_a", mk(1'b0, 2'h0, 16'h1000, 8'h00), op_a);
    n = 0;
    while (key_ready !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    cmp("ready_back", 32'h1, 32'(key_ready));
    cmp_item("x_res", mk(1'b1, 2'h0, 16'h1000, 8'h00), x_disp);
    cmp_item("y_res", mk(1'b0, 2'h0, 16'h2000, 8'h00), y_disp);
    dig(3);
    cmp_item("y_lift", mk(1'b1, 2'h0, 16'h1000, 8'h00), y_disp);
    press(rpn_pkg::ENTER_KEY, 5'h00);
    cmp_item("x_3", mk(1'b0, 2'h0, 16'h3000, 8'h00), x_disp);
    press(rpn_pkg::SIGN_TOGGLE_KEY, 5'h00);
    cmp_item("x_chs", mk(1'b1, 2'h0, 16'h3000, 8'h00), x_disp);
    dig(7);
    press(rpn_pkg::PROGRAM_KEY, 5'h00);
    cmp("active_prog", 32'h1, 32'(entry_disp.active));
    press(rpn_pkg::FUNC1_KEY, 5'h02);
    cmp_item("op_b1", mk(1'b0, 2'h0, 16'h7000, 8'h00), op_b);
    n = 0;
    while (key_ready !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    cmp("ready_fn1", 32'h1, 32'(key_ready));
    cmp_item("x_fn1", mk(1'b1, 2'h0, 16'h1000, 8'h00), x_disp);
    cmp_item("y_fn1", mk(1'b1, 2'h0, 16'h3000, 8'h00), y_disp);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    key_valid = 1'b0;
    key = '0;
    errors = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    t_mantissa();
    t_point();
    t_twelve();
    t_expo();
    t_shift();
    t_stack();
    t_func();
    summarize();
  end
endmodule // tb

/* hw/rpn_normalize.sv */
// Turns the keyed entry buffer into a stack value.
// Assumes digits are stored in keying order and dp_pos counts digits
// before the point.
`timescale 1ns/1ps

module rpn_normalize (
  input wire rpn_pkg::rpn_digs_t digs,
  input wire logic [3:0] ndig,
  input wire logic [3:0] dp_pos,
  input wire logic neg,
  input wire logic [rpn_pkg::EXP_DIG-1:0][3:0] edig,
  input wire logic eneg,
  output rpn_pkg::rpn_item_t item
);

  // ----------------------------------------------------------------
  // Rounding and engineering exponent
  // ----------------------------------------------------------------
  // RULE15 round and normalise
  always_comb begin
    int f;
    int e;
    int mv;
    int idx;
    int lead;
    int expv;
    f = rpn_pkg::MAX_CH;
    e = 0;
    mv = 0;
    idx = 0;
    lead = 0;
    expv = int'(edig[1]) * rpn_pkg::RADIX + int'(edig[0]);
    item = '0;
    for (int i = rpn_pkg::MAX_CH - 1; i >= 0; i--) begin
      if (i < int'(ndig) && digs[i] != 4'h0) begin
        f = i;
      end
    end
    for (int k = 0; k < rpn_pkg::SIG_DIG; k++) begin
      idx = f + k;
      if (idx < int'(ndig)) begin
        mv = mv * rpn_pkg::RADIX + int'(digs[idx]);
      end else begin
        mv = mv * rpn_pkg::RADIX;
      end
    end
    idx = f + rpn_pkg::SIG_DIG;
    if (idx < int'(ndig)) begin
      if (digs[idx] >= rpn_pkg::ROUND_AT) begin
        mv = mv + 1;
      end
    end
    e = int'(dp_pos) - f - 1 + (eneg ? -expv : expv);
    // Rounding past 9999 needs one more decade
    if (mv == rpn_pkg::MANT_TOP) begin
      mv = rpn_pkg::MANT_LOW;
      e = e + 1;
    end
    lead = ((e % rpn_pkg::ENG_STEP) + rpn_pkg::ENG_STEP) % rpn_pkg::ENG_STEP;
    // An all-zero buffer stays the zero item
    if (f < rpn_pkg::MAX_CH) begin
      item.neg = neg;
      item.ipos = 2'(lead);
      item.expo = 8'(e - lead);
      item.mant = {4'(mv / rpn_pkg::MANT_LOW),
                   4'((mv / (rpn_pkg::RADIX * rpn_pkg::RADIX)) % rpn_pkg::RADIX),
                   4'((mv / rpn_pkg::RADIX) % rpn_pkg::RADIX),
                   4'(mv % rpn_pkg::RADIX)};
    end
  end

endmodule // rpn_normalize

/* hw/rpn_pkg.sv */
// Shared types and constants of the operand stack and entry parser.
// Assumes one clock; keys and results come from logic on that clock.
//
// Summary of operation
// RULE1: Stack is five registers, deepest to bottom; bottom two are displayed.
// RULE2: A register holds a constant or a waveform reference tag, flagged.
// RULE3: Values enter and leave the stack only through the bottom register.
// RULE4: Push shifts every register one deeper, deepest lost, then writes bottom.
// RULE5: Pop delivers bottom, moves others down one, deepest keeps its value.
// RULE6: A second decimal point in mantissa is dropped with a warning.
// RULE7: Mantissa takes at most 12 characters; extra ones dropped with warning.
// RULE8: Mantissa sign starts positive; each sign toggle inverts it.
// RULE9: Mantissa ends on exponent, enter or other command except toggle/program keys.
// RULE10: Exponent key with no mantissa assumes and shows mantissa 1.
// RULE11: Exponent keeps only the two most recent digits.
// RULE12: Point or repeated exponent key in exponent entry dropped with warning.
// RULE13: Exponent sign starts positive; each sign toggle inverts it.
// RULE14: Exponent ends on enter or other command except toggle/program keys.
// RULE15: Ending entry normalises to four digits from 1.000 to 999.9.
// RULE16: Entry warnings carry no general warning message.
// RULE17: New characters appear right of earlier ones; minus shown when negative.
// RULE18: Clear entry pops the stack instead of writing zero.
// RULE19: Shift in entry blanks five display characters; shift clear restores.
// RULE20: Enter ends the entry so the next number is a separate operand.
// RULE21: Function key runs at once when the processor is not busy.
// RULE22: Two-operand function pops twice, then pushes its result.
// RULE23: Digits after a completed function push the prior result first.
// RULE24: Dropped keystroke gives one-cycle warning; keys held off while busy.

package rpn_pkg;

  // ----------------------------------------------------------------
  // Sizes and figures
  // ----------------------------------------------------------------
  localparam int DEPTH = 5;
  localparam int MAX_CH = 12;
  localparam int EXP_DIG = 2;
  localparam int SIG_DIG = 4;
  localparam int ENG_STEP = 3;
  localparam int RADIX = 10;
  localparam int MANT_LOW = 1000;
  localparam int MANT_TOP = 10000;
  localparam logic [3:0] ROUND_AT = 4'h5;
  localparam logic [3:0] DEF_MANT = 4'h1;
  localparam logic [2:0] BLANK_CH = 3'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DIGIT_KEY, POINT_KEY, SIGN_TOGGLE_KEY, EXPONENT_ENTRY_KEY, ENTER_KEY,
    CLEAR_ENTRY_POP_KEY, SHIFT_KEY, SHIFT_CLEAR_KEY, PROGRAM_KEY,
    FUNC1_KEY, FUNC2_KEY
  } rpn_kind_t;

  typedef struct packed {
    rpn_kind_t kind;
    logic [4:0] val;
  } rpn_key_t;

  // Mantissa is four BCD digits; ipos+1 digits stand before the point.
  // With the tag flag set, mant holds the waveform memory number.
  typedef struct packed {
    logic waveform_reference_tag;
    logic neg;
    logic [1:0] ipos;
    logic [15:0] mant;
    logic signed [7:0] expo;
  } rpn_item_t;

  typedef logic [MAX_CH-1:0][3:0] rpn_digs_t;

  typedef struct packed {
    logic active;
    logic neg;
    logic [3:0] ndig;
    logic has_dp;
    logic [3:0] dp_pos;
    rpn_digs_t digs;
    logic in_exp;
    logic eneg;
    logic [EXP_DIG-1:0][3:0] edig;
    logic [2:0] blank;
  } rpn_entry_t;

  typedef enum logic [2:0] {S_IDLE, S_MANT, S_EXPO, S_POP, S_WAIT} rpn_state_t;
  typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_POP, OP_WRX} rpn_op_t;

endpackage

/* hw/rpn_stack_entry.sv */
// Operand stack with keystroke entry parser and function dispatch.
// Assumes keys and processor results come from logic on the same clock.
`timescale 1ns/1ps

module rpn_stack_entry (
  input wire logic clock,
  input wire logic rstn,
  input wire logic key_valid,
  input wire rpn_pkg::rpn_key_t key,
  output logic key_ready,
  output logic entry_warn,
  output rpn_pkg::rpn_item_t x_disp,
  output rpn_pkg::rpn_item_t y_disp,
  output rpn_pkg::rpn_entry_t entry_disp,
  output logic fn_req,
  output logic [4:0] fn_code,
  output rpn_pkg::rpn_item_t op_a,
  output rpn_pkg::rpn_item_t op_b,
  input wire logic res_valid,
  input wire rpn_pkg::rpn_item_t res_item
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rpn_pkg::rpn_state_t st_r, st_nxt;
  rpn_pkg::rpn_item_t stk_r [rpn_pkg::DEPTH];
  rpn_pkg::rpn_item_t stk_nxt [rpn_pkg::DEPTH];
  rpn_pkg::rpn_entry_t ent_r, ent_nxt;
  rpn_pkg::rpn_item_t opa_r, opa_nxt, opb_r, opb_nxt;
  rpn_pkg::rpn_item_t push_item, norm_item, x_eff;
  rpn_pkg::rpn_op_t op;
  logic lift_r, lift_nxt;
  logic warn_r, warn_nxt;
  logic req_r, req_nxt;
  logic [4:0] fn_r, fn_nxt;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic in_ent, key_take, ent_full;
  logic [3:0] dp_eff;
  logic [4:0] nchar;

  assign in_ent = (st_r == rpn_pkg::S_MANT) || (st_r == rpn_pkg::S_EXPO);
  // RULE24 hold off while busy
  assign key_ready = (st_r != rpn_pkg::S_POP) && (st_r != rpn_pkg::S_WAIT);
  assign key_take = key_valid && key_ready;
  assign nchar = {1'b0, ent_r.ndig} + {4'h0, ent_r.has_dp};
  assign ent_full = nchar >= 5'(rpn_pkg::MAX_CH);
  assign dp_eff = ent_r.has_dp ? ent_r.dp_pos : ent_r.ndig;
  // RULE3 operands only via bottom
  assign x_eff = in_ent ? norm_item : stk_r[0];

  rpn_normalize u_norm (
    .digs(ent_r.digs),
    .ndig(ent_r.ndig),
    .dp_pos(dp_eff),
    .neg(ent_r.neg),
    .edig(ent_r.edig),
    .eneg(ent_r.eneg),
    .item(norm_item)
  );

  // Fresh entry buffer for a key that opens numeric entry
  function automatic rpn_pkg::rpn_entry_t open_entry(input rpn_pkg::rpn_key_t k);
    rpn_pkg::rpn_entry_t e;
    e = '0;
    e.active = 1'b1;
    if (k.kind == rpn_pkg::DIGIT_KEY) begin
      e.digs[0] = k.val[3:0];
      e.ndig = 4'h1;
    end else if (k.kind == rpn_pkg::POINT_KEY) begin
      e.has_dp = 1'b1;
    end else begin
      // RULE10 default mantissa one
      e.digs[0] = rpn_pkg::DEF_MANT;
      e.ndig = 4'h1;
      e.in_exp = 1'b1;
    end
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Key interpreter
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ent_nxt = ent_r;
    op = rpn_pkg::OP_NONE;
    push_item = norm_item;
    warn_nxt = 1'b0;
    req_nxt = 1'b0;
    lift_nxt = lift_r;
    fn_nxt = fn_r;
    opa_nxt = opa_r;
    opb_nxt = opb_r;
    case (st_r)
      rpn_pkg::S_IDLE, rpn_pkg::S_MANT, rpn_pkg::S_EXPO: begin
        if (key_take) begin
          case (key.kind)
            rpn_pkg::DIGIT_KEY, rpn_pkg::POINT_KEY, rpn_pkg::EXPONENT_ENTRY_KEY: begin
              if (!in_ent) begin
                ent_nxt = open_entry(key);
                st_nxt = ent_nxt.in_exp ? rpn_pkg::S_EXPO : rpn_pkg::S_MANT;
                lift_nxt = 1'b0;
                // RULE23 new entry lifts result
                if (lift_r) begin
                  op = rpn_pkg::OP_PUSH;
                  push_item = stk_r[0];
                end
              end else if (st_r == rpn_pkg::S_EXPO) begin
                if (key.kind == rpn_pkg::DIGIT_KEY) begin
                  // RULE11 keep last two digits
                  ent_nxt.edig = {ent_r.edig[0], key.val[3:0]};
                end else begin
                  // RULE12 point or repeat dropped
                  warn_nxt = 1'b1;
                end
              end else if (key.kind == rpn_pkg::EXPONENT_ENTRY_KEY) begin
                // RULE9 exponent key ends mantissa
                st_nxt = rpn_pkg::S_EXPO;
                ent_nxt.in_exp = 1'b1;
                if (ent_r.ndig == 4'h0) begin
                  ent_nxt.digs[0] = rpn_pkg::DEF_MANT;
                  ent_nxt.ndig = 4'h1;
                  ent_nxt.has_dp = 1'b0;
                end
              end else if (ent_full) begin
                // RULE7 character limit
                warn_nxt = 1'b1;
              end else if (key.kind == rpn_pkg::DIGIT_KEY) begin
                // RULE17 append to the right
                ent_nxt.digs[ent_r.ndig] = key.val[3:0];
                ent_nxt.ndig = ent_r.ndig + 4'h1;
              end else if (ent_r.has_dp) begin
                // RULE6 second point dropped
                warn_nxt = 1'b1;
              end else begin
                ent_nxt.has_dp = 1'b1;
                ent_nxt.dp_pos = ent_r.ndig;
              end
            end
            rpn_pkg::SIGN_TOGGLE_KEY: begin
              if (st_r == rpn_pkg::S_MANT) begin
                // RULE8 mantissa sign toggle
                ent_nxt.neg = !ent_r.neg;
              end else if (st_r == rpn_pkg::S_EXPO) begin
                // RULE13 exponent sign toggle
                ent_nxt.eneg = !ent_r.eneg;
              end else if (!stk_r[0].waveform_reference_tag) begin
                op = rpn_pkg::OP_WRX;
                push_item = stk_r[0];
                push_item.neg = !stk_r[0].neg;
              end
            end
            rpn_pkg::ENTER_KEY: begin
              // RULE20 enter separates operands
              // RULE14 enter ends exponent
              if (in_ent) begin
                op = rpn_pkg::OP_WRX;
              end
              st_nxt = rpn_pkg::S_IDLE;
              ent_nxt = '0;
              lift_nxt = 1'b1;
            end
            rpn_pkg::CLEAR_ENTRY_POP_KEY: begin
              // RULE18 clear pops, no zero write
              op = rpn_pkg::OP_POP;
              st_nxt = rpn_pkg::S_IDLE;
              ent_nxt = '0;
              lift_nxt = 1'b0;
            end
            rpn_pkg::SHIFT_KEY: begin
              // RULE19 blank part of display
              if (in_ent) begin
                ent_nxt.blank = rpn_pkg::BLANK_CH;
              end
            end
            rpn_pkg::SHIFT_CLEAR_KEY: begin
              ent_nxt.blank = 3'h0;
            end
            rpn_pkg::FUNC1_KEY, rpn_pkg::FUNC2_KEY: begin
              // RULE21 execute at once
              op = rpn_pkg::OP_POP;
              opb_nxt = x_eff;
              fn_nxt = key.val;
              ent_nxt = '0;
              if (key.kind == rpn_pkg::FUNC2_KEY) begin
                st_nxt = rpn_pkg::S_POP;
              end else begin
                st_nxt = rpn_pkg::S_WAIT;
                req_nxt = 1'b1;
              end
            end
            default: begin
              // Program keys leave entry untouched
            end
          endcase
        end
      end
      rpn_pkg::S_POP: begin
        // RULE22 second operand pop
        op = rpn_pkg::OP_POP;
        opa_nxt = stk_r[0];
        req_nxt = 1'b1;
        st_nxt = rpn_pkg::S_WAIT;
      end
      rpn_pkg::S_WAIT: begin
        if (res_valid) begin
          // RULE2 result may be a tag
          op = rpn_pkg::OP_PUSH;
          push_item = res_item;
          lift_nxt = 1'b1;
          st_nxt = rpn_pkg::S_IDLE;
        end
      end
      default: begin
        st_nxt = rpn_pkg::S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Stack shifter
  // ----------------------------------------------------------------
  // RULE1 five registers
  for (genvar i = 0; i < rpn_pkg::DEPTH; i++) begin : g_stk
    rpn_pkg::rpn_item_t up, down;
    if (i == 0) begin : g_bot
      assign up = push_item;
    end else begin : g_up
      assign up = stk_r[i-1];
    end
    if (i == rpn_pkg::DEPTH - 1) begin : g_top
      // RULE5 deepest keeps its value
      assign down = stk_r[i];
    end else begin : g_dn
      assign down = stk_r[i+1];
    end
    // RULE4 push shifts deeper
    assign stk_nxt[i] = (op == rpn_pkg::OP_PUSH) ? up :
                        (op == rpn_pkg::OP_POP) ? down :
                        (op == rpn_pkg::OP_WRX && i == 0) ? push_item : stk_r[i];
    always_ff @(posedge clock) begin
      if (!rstn) begin
        stk_r[i] <= '0;
      end else begin
        stk_r[i] <= stk_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_r <= rpn_pkg::S_IDLE;
      ent_r <= '0;
      lift_r <= 1'b0;
      warn_r <= 1'b0;
      req_r <= 1'b0;
      fn_r <= 5'h00;
      opa_r <= '0;
      opb_r <= '0;
    end else begin
      st_r <= st_nxt;
      ent_r <= ent_nxt;
      lift_r <= lift_nxt;
      warn_r <= warn_nxt;
      req_r <= req_nxt;
      fn_r <= fn_nxt;
      opa_r <= opa_nxt;
      opb_r <= opb_nxt;
    end
  end

  // RULE16 quiet warning pulse, no message
  assign entry_warn = warn_r;
  assign x_disp = stk_r[0];
  assign y_disp = stk_r[1];
  assign entry_disp = ent_r;
  assign fn_req = req_r;
  assign fn_code = fn_r;
  assign op_a = opa_r;
  assign op_b = opb_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic tk_d, tk_m, tk_e, tk_i;
  assign tk_d = key_take && key.kind == rpn_pkg::DIGIT_KEY;
  assign tk_m = key_take && st_r == rpn_pkg::S_MANT;
  assign tk_e = key_take && st_r == rpn_pkg::S_EXPO;
  assign tk_i = key_take && st_r == rpn_pkg::S_IDLE;

  a_push_deeper: assert property ( // RULE4
    op == rpn_pkg::OP_PUSH |=> stk_r[1] == $past(stk_r[0]) && stk_r[4] == $past(stk_r[3]))
    else $error("push did not shift deeper");
  a_pop_deep_keep: assert property ( // RULE5
    op == rpn_pkg::OP_POP |=> $stable(stk_r[4]) && stk_r[0] == $past(stk_r[1]))
    else $error("pop shift wrong");
  a_point_twice: assert property ( // RULE6
    tk_m && key.kind == rpn_pkg::POINT_KEY && ent_r.has_dp && !ent_full
    |=> entry_warn && ent_r.dp_pos == $past(ent_r.dp_pos))
    else $error("second point not dropped");
  a_char_limit: assert property ( // RULE7
    tk_m && tk_d && ent_full |=> entry_warn && $stable(ent_r.ndig)
    ##1 (!entry_warn || $past(key_take)))
    else $error("thirteenth character accepted");
  a_mant_sign: assert property ( // RULE8
    tk_m && key.kind == rpn_pkg::SIGN_TOGGLE_KEY |=> ent_r.neg != $past(ent_r.neg))
    else $error("mantissa sign not inverted");
  a_exp_default: assert property ( // RULE10
    tk_i && key.kind == rpn_pkg::EXPONENT_ENTRY_KEY
    |=> st_r == rpn_pkg::S_EXPO && ent_r.digs[0] == rpn_pkg::DEF_MANT)
    else $error("default mantissa missing");
  a_exp_two_dig: assert property ( // RULE11
    tk_e && tk_d |=> ent_r.edig[1] == $past(ent_r.edig[0])
    && ent_r.edig[0] == $past(key.val[3:0]))
    else $error("exponent digits not shifted");
  a_exp_warn: assert property ( // RULE12
    tk_e && (key.kind == rpn_pkg::POINT_KEY || key.kind == rpn_pkg::EXPONENT_ENTRY_KEY)
    |=> entry_warn && $stable(ent_r.edig))
    else $error("exponent key not dropped");
  a_exp_sign: assert property ( // RULE13
    tk_e && key.kind == rpn_pkg::SIGN_TOGGLE_KEY |=> ent_r.eneg != $past(ent_r.eneg))
    else $error("exponent sign not inverted");
  a_norm_lead: assert property ( // RULE15
    key_take && in_ent && key.kind == rpn_pkg::ENTER_KEY && norm_item.mant != 16'h0000
    |=> x_disp.mant[15:12] != 4'h0)
    else $error("normalised mantissa has zero lead");
  a_clear_pops: assert property ( // RULE18
    key_take && key.kind == rpn_pkg::CLEAR_ENTRY_POP_KEY |=> x_disp == $past(y_disp))
    else $error("clear did not pop");
  a_two_pops: assert property ( // RULE22
    key_take && key.kind == rpn_pkg::FUNC2_KEY
    |=> st_r == rpn_pkg::S_POP ##1 fn_req && op_a == $past(x_disp))
    else $error("two-operand pops wrong");
  a_busy_hold: assert property ( // RULE24
    fn_req |-> !key_ready)
    else $error("keys accepted while busy");

  c_exp_entry: cover property (tk_e ##[1:20] key_take && key.kind == rpn_pkg::ENTER_KEY);
  c_fn2_done: cover property (st_r == rpn_pkg::S_POP ##[1:20] res_valid);
  c_char_warn: cover property (tk_m && tk_d && ent_full);
  c_blank: cover property (ent_r.blank == rpn_pkg::BLANK_CH);

endmodule // rpn_stack_entry
